// >>> epwd_canon_check.sv
`timescale 1ns/10ps
module epwd_canon_check #(
  parameter int unsigned VA_BITS = 48
) (
  // Address under test
  input wire logic [63:0] va,
  // Result
  output logic canonical
);
  import epwd_pkg::*;

  // All bits from the top implemented bit through bit 63 must agree. [RULE11]
  assign canonical = (&va[63:VA_BITS-1]) | ~(|va[63:VA_BITS-1]);
endmodule

// >>> epwd_pkg.sv
package epwd_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned APB_AW = 8;
  localparam int unsigned PA_W = 52;
  localparam int unsigned ENTRY_W = 64;
  localparam int unsigned VA_W = 64;
  localparam int unsigned VA_IMPL_BITS = 48;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROOT_LO = 8'h04;
  localparam logic [7:0] OFS_ROOT_HI = 8'h08;
  localparam logic [7:0] OFS_VA_LO = 8'h0c;
  localparam logic [7:0] OFS_VA_HI = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PA_LO = 8'h1c;
  localparam logic [7:0] OFS_PA_HI = 8'h20;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned CTRL_EXT_EN = 0;
  localparam int unsigned CTRL_LPE_EN = 1;
  localparam int unsigned CTRL_LONG_REQ = 2;
  localparam int unsigned CTRL_STACK_REF = 3;
  localparam int unsigned CMD_START = 0;
  localparam int unsigned ENT_PRESENT = 0;
  localparam int unsigned ENT_RW = 1;
  localparam int unsigned ENT_US = 2;
  localparam int unsigned ENT_SIZE_SEL = 7;
  localparam int unsigned ENT_NO_EXEC = 63;

  // ------------------------------------------------------------------
  // Must-be-zero masks per entry kind
  // ------------------------------------------------------------------
  localparam logic [63:0] ZERO_LEG_PTR = 64'hfff0_0000_0000_01e6;
  localparam logic [63:0] ZERO_LEG_TBL = 64'h7ff0_0000_0000_0000;
  localparam logic [63:0] ZERO_LEG_2M = 64'h7ff0_0000_001f_e000;
  localparam logic [63:0] ZERO_LM_TOP = 64'h0000_0000_0000_0180;
  localparam logic [63:0] ZERO_LM_PTR = 64'h0000_0000_0000_0080;
  localparam logic [63:0] ZERO_LM_2M = 64'h0000_0000_001f_e000;
  localparam logic [63:0] ZERO_LM_1G = 64'h0000_0000_3fff_e000;

  // ------------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    EPWD_IDLE = 3'b000,
    EPWD_TOP = 3'b001,
    EPWD_PTR = 3'b010,
    EPWD_DIR = 3'b011,
    EPWD_FINAL = 3'b100
  } epwd_walk_t;

  typedef enum logic [2:0] {
    FLT_NONE = 3'b000,
    FLT_GEN_PROT = 3'b001,
    FLT_SS = 3'b010,
    FLT_PF_NP = 3'b011,
    FLT_PF_RSVD = 3'b100,
    FLT_NOT_EN = 3'b101
  } epwd_fault_t;

  typedef enum logic [1:0] {
    SZ_4K = 2'b00,
    SZ_2M = 2'b01,
    SZ_1G = 2'b10
  } epwd_size_t;

endpackage

// >>> epwd_table_model.sv
`timescale 1ns/10ps
module epwd_table_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fetch port
  input wire logic tbl_req,
  input wire logic [epwd_pkg::PA_W-1:0] tbl_addr,
  output logic tbl_ack,
  output logic [epwd_pkg::ENTRY_W-1:0] tbl_rdata,
  // Answer speed
  input wire logic slow
);
  import epwd_pkg::*;
  // ------------------------------------------------------------------
  // Table storage
  // ------------------------------------------------------------------
  // Unwritten entries answer zero, so a stray address shows up as not present.
  logic [ENTRY_W-1:0] mem [logic [PA_W-1:0]];
  int n_fetch = 0;
  int wait_n = 0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_ack <= 1'b0;
      tbl_rdata <= '1;
    end else if (tbl_ack && tbl_req) begin
      tbl_ack <= 1'b0;
      tbl_rdata <= ~tbl_rdata;
      n_fetch <= n_fetch + 1;
    end else begin
      // Data is scrambled outside the ack cycle so nothing can lean on a stale entry.
      tbl_ack <= 1'b0;
      tbl_rdata <= ~tbl_rdata;
      if (tbl_req && wait_n >= (slow ? 3 : 0)) begin
        tbl_ack <= 1'b1;
        tbl_rdata <= mem.exists(tbl_addr) ? mem[tbl_addr] : '0;
        wait_n <= 0;
      end else if (tbl_req) begin
        wait_n <= wait_n + 1;
      end
    end
  end
endmodule

// >>> epwd_walker.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
// Contract
// RULE1: Legacy 2M: VA 31:30 picks pointer entry.
// RULE2: Legacy 2M: VA 29:21 indexes directory.
// RULE3: 2M offset is VA 20:0 unchanged.
// RULE4: 2M translation stops at directory level.
// RULE5: Directory size-select bit set maps 2M.
// RULE6: Long mode without extension raises protection fault.
// RULE7: 64-bit entries, up to 52-bit physical.
// RULE8: Long walk starts at top-level map table.
// RULE9: Long mode: size bit decides, ignore legacy enable.
// RULE10: Pointer entry size bit maps 1G page.
// RULE11: Canonical means top bits all equal.
// RULE12: Non-canonical gives protection fault, or stack fault.
// RULE13: Long-mode pointer entry control bits honoured.
// RULE14: Legacy 4K: VA 20:12 indexes final table.
// RULE15: Extended paging only while enable set.
// RULE16: Set must-be-zero bit gives reserved fault.
// RULE17: Software clears must-be-zero fields first.
module epwd_walker #(
  parameter bit GIG_PAGES = 1'b1,
  parameter int unsigned VA_BITS = epwd_pkg::VA_IMPL_BITS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [epwd_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Table storage read port
  output logic tbl_req,
  output logic [epwd_pkg::PA_W-1:0] tbl_addr,
  input wire logic tbl_ack,
  input wire logic [epwd_pkg::ENTRY_W-1:0] tbl_rdata
);
  import epwd_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    epwd_walk_t walk;
    logic ext_en;
    logic lpe_en;
    logic long_req;
    logic stack_ref;
    logic lm_active;
    logic [PA_W-1:0] root;
    logic [63:0] va;
    logic [PA_W-1:0] pa;
    epwd_size_t size;
    epwd_fault_t fault;
    logic done;
    logic wr_ok;
    logic usr_ok;
    logic no_exec;
    logic req;
    logic [PA_W-1:0] addr;
    logic [31:0] rdata;
    logic slverr;
  } epwd_state_t;

  epwd_state_t st_q;
  epwd_state_t st_d;
  logic canonical;
  logic setup;
  logic access_wr;
  logic start;
  logic ack;
  logic [63:0] zero_mask;
  logic [63:0] ent;
  logic leaf_2m;
  logic leaf_1g;

  epwd_canon_check #(
    .VA_BITS(VA_BITS)
  ) epwd_canon_check_inst (
    .va(st_q.va),
    .canonical(canonical)
  );

  assign setup = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign start = access_wr && paddr == OFS_CMD && pwdata[CMD_START] && st_q.walk == EPWD_IDLE;
  assign ack = tbl_ack && st_q.req && st_q.walk != EPWD_IDLE;
  assign ent = tbl_rdata;
  // The legacy size-extension enable plays no part in either mode here. [RULE9]
  assign leaf_2m = st_q.walk == EPWD_DIR && ent[ENT_SIZE_SEL]; // [RULE5]
  assign leaf_1g = GIG_PAGES && st_q.lm_active && st_q.walk == EPWD_PTR && ent[ENT_SIZE_SEL]; // [RULE10]

  // ------------------------------------------------------------------
  // Must-be-zero selection
  // ------------------------------------------------------------------
  always_comb begin
    case (st_q.walk)
      EPWD_TOP: zero_mask = ZERO_LM_TOP;
      EPWD_PTR: zero_mask = !st_q.lm_active ? ZERO_LEG_PTR :
                            (leaf_1g ? ZERO_LM_1G : (GIG_PAGES ? 64'h0 : ZERO_LM_PTR));
      EPWD_DIR: zero_mask = st_q.lm_active ? (leaf_2m ? ZERO_LM_2M : 64'h0) :
                            (leaf_2m ? ZERO_LEG_2M : ZERO_LEG_TBL);
      EPWD_FINAL: zero_mask = st_q.lm_active ? 64'h0 : ZERO_LEG_TBL;
      default: zero_mask = 64'h0;
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Read data is captured in the setup phase so the zero-wait access phase sees a flop.
    if (setup) begin
      st_d.slverr = 1'b0;
      case (paddr)
        OFS_CTRL: st_d.rdata = {28'h0, st_q.stack_ref, st_q.long_req, st_q.lpe_en, st_q.ext_en};
        OFS_ROOT_LO: st_d.rdata = st_q.root[31:0];
        OFS_ROOT_HI: st_d.rdata = {12'h0, st_q.root[PA_W-1:32]};
        OFS_VA_LO: st_d.rdata = st_q.va[31:0];
        OFS_VA_HI: st_d.rdata = st_q.va[63:32];
        OFS_CMD: st_d.rdata = 32'h0;
        OFS_STATUS: st_d.rdata = {21'h0, st_q.no_exec, st_q.usr_ok, st_q.wr_ok, st_q.size, st_q.lm_active,
                                  st_q.fault, st_q.done, st_q.walk != EPWD_IDLE};
        OFS_PA_LO: st_d.rdata = st_q.pa[31:0];
        OFS_PA_HI: st_d.rdata = {12'h0, st_q.pa[PA_W-1:32]};
        default: begin
          st_d.rdata = 32'h0;
          st_d.slverr = 1'b1;
        end
      endcase
    end
    if (access_wr) begin
      case (paddr)
        OFS_CTRL: begin
          st_d.ext_en = pwdata[CTRL_EXT_EN];
          st_d.lpe_en = pwdata[CTRL_LPE_EN];
          st_d.stack_ref = pwdata[CTRL_STACK_REF];
          // Long mode is refused while the extension is off. [RULE6] [RULE15]
          if (pwdata[CTRL_LONG_REQ] && !pwdata[CTRL_EXT_EN]) begin
            st_d.long_req = 1'b0;
            st_d.lm_active = 1'b0;
            st_d.fault = FLT_GEN_PROT;
          end else begin
            st_d.long_req = pwdata[CTRL_LONG_REQ];
            st_d.lm_active = pwdata[CTRL_LONG_REQ];
          end
        end
        OFS_ROOT_LO: st_d.root[31:0] = pwdata;
        OFS_ROOT_HI: st_d.root[PA_W-1:32] = pwdata[PA_W-33:0];
        OFS_VA_LO: st_d.va[31:0] = pwdata;
        OFS_VA_HI: st_d.va[63:32] = pwdata;
        default: ;
      endcase
    end
    if (start) begin
      st_d.done = 1'b0;
      st_d.fault = FLT_NONE;
      st_d.wr_ok = 1'b1;
      st_d.usr_ok = 1'b1;
      st_d.no_exec = 1'b0;
      st_d.size = SZ_4K;
      if (!st_q.ext_en) begin
        st_d.fault = FLT_NOT_EN; // [RULE15]
        st_d.done = 1'b1;
      end else if (st_q.lm_active && !canonical) begin
        st_d.fault = st_q.stack_ref ? FLT_SS : FLT_GEN_PROT; // [RULE12]
        st_d.done = 1'b1;
      end else if (st_q.lm_active) begin
        st_d.walk = EPWD_TOP; // [RULE8]
        st_d.req = 1'b1;
        st_d.addr = {st_q.root[PA_W-1:12], st_q.va[47:39], 3'b000};
      end else begin
        st_d.walk = EPWD_PTR;
        st_d.req = 1'b1;
        st_d.addr = {st_q.root[PA_W-1:5], st_q.va[31:30], 3'b000}; // [RULE1]
      end
    end
    // Each fetched entry is 64 bits and carries a 52-bit physical base. [RULE7]
    if (ack) begin
      st_d.req = 1'b0;
      if (!ent[ENT_PRESENT]) begin
        st_d.fault = FLT_PF_NP;
        st_d.walk = EPWD_IDLE;
        st_d.done = 1'b1;
      end else if (|(ent & zero_mask)) begin
        st_d.fault = FLT_PF_RSVD; // [RULE16]
        st_d.walk = EPWD_IDLE;
        st_d.done = 1'b1;
      end else begin
        // Legacy pointer entries lack these bits; long-mode ones carry them. [RULE13]
        if (st_q.lm_active || st_q.walk != EPWD_PTR) begin
          st_d.wr_ok = st_q.wr_ok & ent[ENT_RW];
          st_d.usr_ok = st_q.usr_ok & ent[ENT_US];
          st_d.no_exec = st_q.no_exec | ent[ENT_NO_EXEC];
        end
        case (st_q.walk)
          EPWD_TOP: begin
            st_d.walk = EPWD_PTR;
            st_d.req = 1'b1;
            st_d.addr = {ent[PA_W-1:12], st_q.va[38:30], 3'b000};
          end
          EPWD_PTR: begin
            if (leaf_1g) begin
              st_d.walk = EPWD_IDLE;
              st_d.size = SZ_1G;
              st_d.pa = {ent[PA_W-1:30], st_q.va[29:0]};
              st_d.done = 1'b1;
            end else begin
              st_d.walk = EPWD_DIR;
              st_d.req = 1'b1;
              st_d.addr = {ent[PA_W-1:12], st_q.va[29:21], 3'b000}; // [RULE2]
            end
          end
          EPWD_DIR: begin
            if (leaf_2m) begin
              // No final-level fetch for a large page. [RULE4]
              st_d.walk = EPWD_IDLE;
              st_d.size = SZ_2M;
              st_d.pa = {ent[PA_W-1:21], st_q.va[20:0]}; // [RULE3]
              st_d.done = 1'b1;
            end else begin
              st_d.walk = EPWD_FINAL;
              st_d.req = 1'b1;
              st_d.addr = {ent[PA_W-1:12], st_q.va[20:12], 3'b000}; // [RULE14]
            end
          end
          EPWD_FINAL: begin
            st_d.walk = EPWD_IDLE;
            st_d.pa = {ent[PA_W-1:12], st_q.va[11:0]};
            st_d.done = 1'b1;
          end
          default: st_d.walk = EPWD_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = st_q.rdata;
  assign pslverr = st_q.slverr;
  assign tbl_req = st_q.req;
  assign tbl_addr = st_q.addr;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_long_start;
    start && st_q.lm_active && st_q.ext_en;
  endsequence

  sequence s_dir_big;
    ack && st_q.walk == EPWD_DIR && ent[ENT_PRESENT] && ent[ENT_SIZE_SEL] && !(|(ent & zero_mask));
  endsequence

  a_long_needs_ext: assert property ( // [RULE6]
    access_wr && paddr == OFS_CTRL && pwdata[CTRL_LONG_REQ] && !pwdata[CTRL_EXT_EN]
    |=> st_q.fault == FLT_GEN_PROT && !st_q.lm_active && !st_q.long_req)
    else $error("long mode entered without extension");

  a_big_page_stop: assert property ( // [RULE4]
    s_dir_big |=> (st_q.walk == EPWD_IDLE && st_q.size == SZ_2M && !tbl_req) [*2])
    else $error("final fetch after large directory entry");

  a_big_offset: assert property ( // [RULE3]
    s_dir_big |=> st_q.pa[20:0] == st_q.va[20:0] && st_q.done)
    else $error("large page offset altered");

  a_ptr_index: assert property ( // [RULE1]
    tbl_req && st_q.walk == EPWD_PTR && !st_q.lm_active |-> tbl_addr[4:3] == st_q.va[31:30])
    else $error("pointer index wrong");

  a_dir_index: assert property ( // [RULE2]
    tbl_req && st_q.walk == EPWD_DIR |-> tbl_addr[11:3] == st_q.va[29:21])
    else $error("directory index wrong");

  a_final_index: assert property ( // [RULE14]
    tbl_req && st_q.walk == EPWD_FINAL |-> tbl_addr[11:3] == st_q.va[20:12])
    else $error("final table index wrong");

  a_canon_fault: assert property ( // [RULE12]
    s_long_start and !canonical |=> st_q.done && st_q.walk == EPWD_IDLE
    && st_q.fault == ($past(st_q.stack_ref) ? FLT_SS : FLT_GEN_PROT))
    else $error("non-canonical address not faulted");

  a_top_first: assert property ( // [RULE8]
    s_long_start and canonical |=> st_q.walk == EPWD_TOP && tbl_req && tbl_addr[11:3] == st_q.va[47:39])
    else $error("long walk did not start at top table");

  a_gig_leaf: assert property ( // [RULE10]
    ack && leaf_1g && !(|(ent & zero_mask)) |=> st_q.size == SZ_1G && st_q.pa[29:0] == st_q.va[29:0])
    else $error("1G page not mapped");

  a_rsvd_fault: assert property ( // [RULE16]
    ack && ent[ENT_PRESENT] && |(ent & zero_mask) |=> st_q.fault == FLT_PF_RSVD && st_q.done && !tbl_req)
    else $error("reserved bit not faulted");

  a_no_ext_walk: assert property ( // [RULE15]
    start && !st_q.ext_en |=> st_q.fault == FLT_NOT_EN && !tbl_req)
    else $error("walk ran without extension");
endmodule

// >>> extended_page_walk_decode_bench.sv
`timescale 1ns/10ps
module extended_page_walk_decode_bench;
  import epwd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic pready, pslverr, tbl_req, tbl_ack, slv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [51:0] tbl_addr;
  logic [63:0] tbl_rdata, st, pa;
  int errors = 0, n_checks = 0;
  initial begin
    forever #5 pclk = ~pclk;
  end
  epwd_walker epwd_walker_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tbl_req(tbl_req),
    .tbl_addr(tbl_addr), .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata));
  epwd_table_model epwd_table_model_inst (.pclk(pclk), .presetn(presetn), .tbl_req(tbl_req),
    .tbl_addr(tbl_addr), .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata), .slow(slow));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // The extra idle edge at the end keeps two calls from driving psel in one time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic put(input logic [51:0] a, input logic [63:0] e);
    epwd_table_model_inst.mem[a] = e;
  endtask
  task automatic walk(input logic [63:0] v);
    int k = 0;
    apb(1'b1, OFS_VA_LO, v[31:0]);
    apb(1'b1, OFS_VA_HI, v[63:32]);
    epwd_table_model_inst.n_fetch = 0;
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rd[1:0] !== 2'b10 && k < 100);
    st = {32'h0, rd};
    apb(1'b0, OFS_PA_LO, 32'h0);
    pa[31:0] = rd;
    apb(1'b0, OFS_PA_HI, 32'h0);
    pa[63:32] = rd;
    if (k >= 100) begin
      errors++;
      complete_run();
    end
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk({63'h0, tbl_req}, 64'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({32'h0, rd}, 64'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, slv, rd}, 64'h1_0000_0000);
  endtask
  task automatic t_leg2m();
    logic [51:0] root = 52'h1000;
    logic [63:0] v = 64'h0000_0000_c0a1_2345, p = 64'h2001, d = 64'h0000_0001_4020_0087;
    slow <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, OFS_ROOT_LO, root[31:0]);
    apb(1'b1, OFS_ROOT_HI, 32'h0);
    put({root[51:5], v[31:30], 3'b000}, p);
    put({p[51:12], v[29:21], 3'b000}, d);
    walk(v);
    chk(st, 64'h342);
    chk(pa, {12'h000, d[51:21], v[20:0]});
    chk(64'(epwd_table_model_inst.n_fetch), 64'h2);
    put({p[51:12], v[29:21], 3'b000}, d | 64'h2000);
    walk(v);
    chk({61'h0, st[4:2]}, 64'h4);
    slow <= 1'b0;
  endtask
  task automatic t_leg4k();
    logic [63:0] v = 64'h0000_0000_4123_5678, p = 64'h3001, d = 64'h4003, f = 64'h0000_0005_6789_a007;
    put({47'h80, v[31:30], 3'b000}, p);
    put({p[51:12], v[29:21], 3'b000}, d);
    put({d[51:12], v[20:12], 3'b000}, f);
    walk(v);
    chk(st, 64'h102);
    chk(pa, {12'h000, f[51:12], v[11:0]});
    chk(64'(epwd_table_model_inst.n_fetch), 64'h3);
  endtask
  task automatic t_ext_off();
    apb(1'b1, OFS_CTRL, 32'h0);
    walk(64'h0000_0000_c0a1_2345);
    chk(st, 64'h316);
    chk(64'(epwd_table_model_inst.n_fetch), 64'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_0004);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk({32'h0, rd}, 64'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({61'h0, rd[4:2]}, 64'h1);
  endtask
  task automatic t_canon();
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    walk(64'h0000_8000_0000_0000);
    chk(st, 64'h326);
    apb(1'b1, OFS_CTRL, 32'h0000_000d);
    walk(64'hffff_0000_0000_0000);
    chk(st, 64'h32a);
    chk(64'(epwd_table_model_inst.n_fetch), 64'h0);
  endtask
  task automatic t_long();
    logic [63:0] v = 64'hffff_ff80_4123_4567, t = 64'h5007, p = 64'h0000_0002_c000_0085;
    logic [63:0] p2 = 64'h6007, d = 64'h0000_0003_0020_0087;
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    apb(1'b1, OFS_ROOT_LO, 32'h0000_4000);
    put({40'h4, v[47:39], 3'b000}, t);
    put({t[51:12], v[38:30], 3'b000}, p);
    walk(v);
    chk(st, 64'h2a2);
    chk(pa, {12'h000, p[51:30], v[29:0]});
    put({t[51:12], v[38:30], 3'b000}, p2);
    put({p2[51:12], v[29:21], 3'b000}, d);
    walk(v);
    chk(st, 64'h362);
    chk(pa, {12'h000, d[51:21], v[20:0]});
    chk(64'(epwd_table_model_inst.n_fetch), 64'h3);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_leg2m();
    t_leg4k();
    t_ext_off();
    t_canon();
    t_long();
    complete_run();
  end
endmodule
